/* src/asc_pkg.sv */
// Constants, register map and types of the two-channel serial block
package asc_pkg;
  // Host port offsets; channel B adds the channel base
  localparam logic [3:0] A_MR1 = 4'h0;
  localparam logic [3:0] A_MR2 = 4'h1;
  localparam logic [3:0] A_SR = 4'h2;
  localparam logic [3:0] A_CR = 4'h3;
  localparam logic [3:0] A_DATA = 4'h4;
  localparam logic [3:0] A_CSR = 4'h5;
  localparam logic [3:0] A_IMR = 4'h6;
  localparam logic [3:0] A_OUTPUT_PIN_FUNCTION_SELECT = 4'h7;
  localparam logic [3:0] A_OPSET = 4'hE;
  localparam logic [3:0] A_OPCLR = 4'hF;
  localparam logic [2:0] A_LOC_MAX = 3'h6;
  // Command bits
  localparam int CR_RXEN = 0;
  localparam int CR_RXDIS = 1;
  localparam int CR_TXEN = 2;
  localparam int CR_TXDIS = 3;
  localparam int CR_RSTERR = 4;
  localparam int CR_RSTBRK = 5;
  // Mode fields
  localparam int MR1_RXRTS = 7;
  localparam int MR1_RXINT = 6;
  localparam int MR1_ODD = 2;
  localparam int MR2_TXRTS = 5;
  localparam logic [1:0] PAR_WITH = 2'h0;
  localparam logic [1:0] PAR_NONE = 2'h2;
  // Clock sources
  localparam logic [1:0] SRC_BRG = 2'h0;
  localparam logic [1:0] SRC_CT = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  // Pin 3 and pin 2 selector codes
  localparam logic [1:0] OPS_LATCH = 2'h0;
  localparam logic [1:0] OPS_ALT1 = 2'h1;
  localparam logic [1:0] OPS_ALT2 = 2'h2;
  // Interrupt status positions within a channel nibble
  localparam int ISR_TX = 0;
  localparam int ISR_RX = 1;
  localparam int ISR_DBRK = 2;
  localparam int ISR_CH_W = 4;
  // Reset values and counts
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] START_SMP = 4'h6;
  localparam logic [3:0] BIT_SMP = 4'hF;
  localparam logic [3:0] NB_BASE = 4'h5;
  localparam int RXQ_DEPTH = 3;
  typedef enum logic [0:0] {TX_IDLE, TX_SEND} asc_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} asc_rx_state_t;
endpackage

/* src/asc_top.sv */
// Two serial channels with output pin selector and host port
`timescale 1ns/10ps
module asc_channel import asc_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Host access
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Clock sources
  input wire logic brg_tick_i,
  input wire logic ct_tick_i,
  input wire logic ext_tx_clk_i,
  input wire logic ext_rx_clk_i,
  // Serial line
  input wire logic serial_in_i,
  output logic serial_out_o,
  // Status
  output logic tx_empty_o,
  output logic tx_ready_o,
  output logic rx_ready_o,
  output logic rx_full_o,
  output logic rx_int_o,
  output logic dbrk_o,
  output logic rts_ctl_o,
  output logic rts_neg_o,
  output logic tx16x_o,
  output logic tx1x_o,
  output logic rx1x_o
);
  logic [7:0] mr1_r, mr1_nxt, mr2_r, mr2_nxt;
  logic [3:0] csr_r, csr_nxt;
  logic tx_en_r, tx_en_nxt, rx_en_r, rx_en_nxt;
  logic ext_tx_d_r, ext_rx_d_r;
  logic [7:0] thr_r, thr_nxt;
  logic thr_full_r, thr_full_nxt;
  logic [11:0] tsr_r, tsr_nxt;
  logic [3:0] tx_left_r, tx_left_nxt, tx_pre_r, tx_pre_nxt;
  logic tx_tgl_r, tx_tgl_nxt, sout_r, sout_nxt;
  asc_tx_state_t tx_st_r, tx_st_nxt;
  asc_rx_state_t rx_st_r, rx_st_nxt;
  logic [3:0] rx_smp_r, rx_smp_nxt, rx_idx_r, rx_idx_nxt, rx_div_r, rx_div_nxt;
  logic [7:0] rsr_r, rsr_nxt;
  logic par_r, par_nxt, zero_r, zero_nxt, rx_last_r, rx_last_nxt;
  logic [10:0] q_r [RXQ_DEPTH];
  logic [10:0] q_nxt [RXQ_DEPTH];
  logic [1:0] q_cnt_r, q_cnt_nxt;
  logic [10:0] hold_r, hold_nxt;
  logic hold_full_r, hold_full_nxt;
  logic oe_r, oe_nxt, dbrk_r, dbrk_nxt;
  logic tx_tick, rx_tick, bit_tick, wr_cr, pop;
  logic push;
  logic [10:0] push_w;
  logic [3:0] nb;
  logic par_en, exp_par;
  logic [10:0] top_w;

  // Mask of the active data bits for a character length
  function automatic logic [7:0] dmask(input logic [3:0] n);
    return 8'hFF >> (4'h8 - n);
  endfunction

  // Selected 16x tick for one direction
  function automatic logic pick_tick(input logic [1:0] s, input logic b, input logic c, input logic e);
    return (s == SRC_BRG) ? b : (s == SRC_CT) ? c : (s == SRC_EXT) ? e : 1'b0;
  endfunction

  // Expected parity bit for data under the current mode
  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] m1, input logic [3:0] n);
    return (m1[4:3] == PAR_WITH) ? ((^(d & dmask(n))) ^ m1[MR1_ODD]) : m1[MR1_ODD];
  endfunction

  // Shared decode of mode, clock select and host port
  assign nb = NB_BASE + {2'b00, mr1_r[1:0]};
  assign par_en = (mr1_r[4:3] != PAR_NONE);
  assign tx_tick = pick_tick(csr_r[1:0], brg_tick_i, ct_tick_i, ext_tx_clk_i & ~ext_tx_d_r);
  assign rx_tick = pick_tick(csr_r[3:2], brg_tick_i, ct_tick_i, ext_rx_clk_i & ~ext_rx_d_r);
  assign bit_tick = tx_tick & (tx_pre_r == BIT_SMP);
  assign wr_cr = wr_i & (addr_i == A_CR[2:0]);
  assign pop = rd_i & (addr_i == A_DATA[2:0]) & (q_cnt_r != 2'h0);
  assign top_w = (q_cnt_r != 2'h0) ? q_r[0] : 11'h000;

  // Configuration and command next values
  always_comb begin
    mr1_nxt = mr1_r;
    mr2_nxt = mr2_r;
    csr_nxt = csr_r;
    tx_en_nxt = tx_en_r;
    rx_en_nxt = rx_en_r;
    if (wr_i && addr_i == A_MR1[2:0]) mr1_nxt = wdata_i;
    if (wr_i && addr_i == A_MR2[2:0]) mr2_nxt = wdata_i;
    if (wr_i && addr_i == A_CSR[2:0]) csr_nxt = wdata_i[3:0];
    if (wr_cr && wdata_i[CR_TXEN]) tx_en_nxt = 1'b1;
    if (wr_cr && wdata_i[CR_TXDIS]) tx_en_nxt = 1'b0;
    if (wr_cr && wdata_i[CR_RXEN]) rx_en_nxt = 1'b1;
    if (wr_cr && wdata_i[CR_RXDIS]) rx_en_nxt = 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mr1_r <= RST_BYTE;
      mr2_r <= RST_BYTE;
      csr_r <= 4'h0;
      tx_en_r <= 1'b0;
      rx_en_r <= 1'b0;
      ext_tx_d_r <= 1'b0;
      ext_rx_d_r <= 1'b0;
    end else begin
      mr1_r <= mr1_nxt;
      mr2_r <= mr2_nxt;
      csr_r <= csr_nxt;
      tx_en_r <= tx_en_nxt;
      rx_en_r <= rx_en_nxt;
      ext_tx_d_r <= ext_tx_clk_i;
      ext_rx_d_r <= ext_rx_clk_i;
    end
  end

  // Transmitter next values
  always_comb begin
    logic [11:0] fr;
    fr = 12'hFFF;
    thr_nxt = thr_r;
    thr_full_nxt = thr_full_r;
    tsr_nxt = tsr_r;
    tx_left_nxt = tx_left_r;
    tx_st_nxt = tx_st_r;
    sout_nxt = sout_r;
    tx_pre_nxt = tx_pre_r + {3'h0, tx_tick};
    tx_tgl_nxt = tx_tgl_r ^ tx_tick;
    // Frame: start, data LSB first, parity, stop
    fr[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < nb) fr[i+1] = thr_r[i];
    end
    if (par_en) fr[nb+4'h1] = par_bit(thr_r, mr1_r, nb);
    unique case (tx_st_r)
      TX_IDLE: begin
        sout_nxt = 1'b1;
        if (bit_tick && thr_full_r) begin
          tsr_nxt = fr;
          sout_nxt = fr[0];
          tx_left_nxt = nb + (par_en ? 4'h2 : 4'h1);
          thr_full_nxt = 1'b0;
          tx_st_nxt = TX_SEND;
        end
      end
      TX_SEND: begin
        if (bit_tick && tx_left_r != 4'h0) begin
          tsr_nxt = {1'b1, tsr_r[11:1]};
          sout_nxt = tsr_r[1];
          tx_left_nxt = tx_left_r - 4'h1;
        end else if (bit_tick && thr_full_r) begin
          tsr_nxt = fr;
          sout_nxt = fr[0];
          tx_left_nxt = nb + (par_en ? 4'h2 : 4'h1);
          thr_full_nxt = 1'b0;
        end else if (bit_tick) begin
          sout_nxt = 1'b1;
          tx_st_nxt = TX_IDLE;
        end
      end
    endcase
    // Host write accepted only while enabled and buffer free
    if (wr_i && addr_i == A_DATA[2:0] && tx_en_r && !thr_full_r) begin
      thr_nxt = wdata_i;
      thr_full_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      thr_r <= RST_BYTE;
      thr_full_r <= 1'b0;
      tsr_r <= 12'hFFF;
      tx_left_r <= 4'h0;
      tx_pre_r <= 4'h0;
      tx_tgl_r <= 1'b0;
      sout_r <= 1'b1;
      tx_st_r <= TX_IDLE;
    end else begin
      thr_r <= thr_nxt;
      thr_full_r <= thr_full_nxt;
      tsr_r <= tsr_nxt;
      tx_left_r <= tx_left_nxt;
      tx_pre_r <= tx_pre_nxt;
      tx_tgl_r <= tx_tgl_nxt;
      sout_r <= sout_nxt;
      tx_st_r <= tx_st_nxt;
    end
  end

  // Receiver, queue and error flag next values
  always_comb begin
    logic [1:0] cnt;
    cnt = q_cnt_r;
    rx_st_nxt = rx_st_r;
    rx_smp_nxt = rx_smp_r;
    rx_idx_nxt = rx_idx_r;
    rx_div_nxt = rx_div_r + {3'h0, rx_tick};
    rsr_nxt = rsr_r;
    par_nxt = par_r;
    zero_nxt = zero_r;
    rx_last_nxt = rx_tick ? serial_in_i : rx_last_r; // Line level at the previous tick
    hold_nxt = hold_r;
    hold_full_nxt = hold_full_r;
    for (int i = 0; i < RXQ_DEPTH; i++) q_nxt[i] = q_r[i];
    push = 1'b0;
    push_w = 11'h000;
    oe_nxt = oe_r & ~(wr_cr & wdata_i[CR_RSTERR]);
    dbrk_nxt = dbrk_r & ~(wr_cr & wdata_i[CR_RSTBRK]);
    exp_par = par_bit(rsr_r, mr1_r, nb);
    unique case (rx_st_r)
      RX_IDLE: begin
        // Falling edge only, so a line still low after a bad stop is not a start
        if (rx_tick && rx_en_r && !serial_in_i && rx_last_r) begin
          rx_smp_nxt = 4'h1;
          rx_st_nxt = RX_START;
        end
      end
      RX_START: begin
        if (rx_tick && rx_smp_r == START_SMP) begin
          if (!serial_in_i) begin
            rx_st_nxt = RX_DATA;
            rx_smp_nxt = 4'h0;
            rx_idx_nxt = 4'h0;
            rsr_nxt = 8'h00;
            zero_nxt = 1'b1;
          end else begin
            rx_st_nxt = RX_IDLE;
          end
        end else if (rx_tick) begin
          rx_smp_nxt = rx_smp_r + 4'h1;
        end
      end
      RX_DATA, RX_PAR, RX_STOP: begin
        if (rx_tick && rx_smp_r != BIT_SMP) begin
          rx_smp_nxt = rx_smp_r + 4'h1;
        end else if (rx_tick) begin
          // Mid-bit sample, one bit period after the last
          rx_smp_nxt = 4'h0;
          zero_nxt = zero_r & ~serial_in_i;
          if (rx_st_r == RX_DATA) begin
            rsr_nxt[rx_idx_r[2:0]] = serial_in_i;
            rx_idx_nxt = rx_idx_r + 4'h1;
            if (rx_idx_r == nb - 4'h1) rx_st_nxt = par_en ? RX_PAR : RX_STOP;
          end else if (rx_st_r == RX_PAR) begin
            par_nxt = serial_in_i;
            rx_st_nxt = RX_STOP;
          end else begin
            push = 1'b1;
            if (!serial_in_i && zero_r) begin
              push_w = {1'b1, 1'b1, 1'b0, 8'h00};
              dbrk_nxt = 1'b1;
              rx_st_nxt = RX_BRK;
            end else begin
              push_w = {1'b0, ~serial_in_i, par_en & (par_r != exp_par), rsr_r & dmask(nb)};
              rx_st_nxt = RX_IDLE;
            end
          end
        end
      end
      RX_BRK: begin
        if (serial_in_i) begin
          dbrk_nxt = 1'b1;
          rx_st_nxt = RX_IDLE;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    // Queue: pop, refill from the holding register, then push
    if (pop) begin
      q_nxt[0] = q_r[1];
      q_nxt[1] = q_r[2];
      cnt = cnt - 2'h1;
      if (hold_full_r) begin
        q_nxt[cnt] = hold_r;
        cnt = cnt + 2'h1;
        hold_full_nxt = 1'b0;
      end
    end
    if (push && cnt != 2'(RXQ_DEPTH) && !hold_full_nxt) begin
      q_nxt[cnt] = push_w;
      cnt = cnt + 2'h1;
    end else if (push) begin
      if (hold_full_nxt) oe_nxt = 1'b1;
      hold_nxt = push_w;
      hold_full_nxt = 1'b1;
    end
    q_cnt_nxt = cnt;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_st_r <= RX_IDLE;
      rx_smp_r <= 4'h0;
      rx_idx_r <= 4'h0;
      rx_div_r <= 4'h0;
      rsr_r <= 8'h00;
      par_r <= 1'b0;
      zero_r <= 1'b0;
      rx_last_r <= 1'b1;
      for (int i = 0; i < RXQ_DEPTH; i++) q_r[i] <= 11'h000;
      q_cnt_r <= 2'h0;
      hold_r <= 11'h000;
      hold_full_r <= 1'b0;
      oe_r <= 1'b0;
      dbrk_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_smp_r <= rx_smp_nxt;
      rx_idx_r <= rx_idx_nxt;
      rx_div_r <= rx_div_nxt;
      rsr_r <= rsr_nxt;
      par_r <= par_nxt;
      zero_r <= zero_nxt;
      rx_last_r <= rx_last_nxt;
      for (int i = 0; i < RXQ_DEPTH; i++) q_r[i] <= q_nxt[i];
      q_cnt_r <= q_cnt_nxt;
      hold_r <= hold_nxt;
      hold_full_r <= hold_full_nxt;
      oe_r <= oe_nxt;
      dbrk_r <= dbrk_nxt;
    end
  end

  // Status and read data
  assign tx_empty_o = ~thr_full_r & (tx_st_r == TX_IDLE);
  assign tx_ready_o = tx_en_r & ~thr_full_r;
  assign rx_ready_o = (q_cnt_r != 2'h0);
  assign rx_full_o = (q_cnt_r == 2'(RXQ_DEPTH));
  assign rx_int_o = mr1_r[MR1_RXINT] ? rx_full_o : rx_ready_o;
  assign dbrk_o = dbrk_r;
  assign rts_ctl_o = mr1_r[MR1_RXRTS] | mr2_r[MR2_TXRTS];
  assign rts_neg_o = (mr1_r[MR1_RXRTS] & rx_full_o) | (mr2_r[MR2_TXRTS] & ~tx_en_r & tx_empty_o);
  assign serial_out_o = sout_r;
  assign tx16x_o = tx_tgl_r;
  assign tx1x_o = tx_pre_r[3];
  assign rx1x_o = rx_div_r[3];
  always_comb begin
    case (addr_i)
      A_MR1[2:0]: rdata_o = mr1_r;
      A_MR2[2:0]: rdata_o = mr2_r;
      A_SR[2:0]: rdata_o = {top_w[10:8], oe_r, tx_empty_o, tx_ready_o, rx_full_o, rx_ready_o};
      A_DATA[2:0]: rdata_o = top_w[7:0];
      default: rdata_o = 8'h00;
    endcase
  end
endmodule

module asc_top import asc_pkg::*; #(
  parameter int unsigned BRG_DIV = 65,
  parameter int unsigned CT_DIV = 1000
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Host port
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Serial lines, index 0 is channel A
  input wire logic [1:0] serial_in_i,
  output logic [1:0] serial_out_o,
  input wire logic [1:0] ext_tx_clk_i,
  input wire logic [1:0] ext_rx_clk_i,
  // Output port pins
  output logic [7:0] op_o,
  output logic [7:0] op_oe_n_o,
  output logic irq_o
);
  logic [7:0] opr_r, opr_nxt, output_pin_function_select_r, output_pin_function_select_nxt, imr_r, imr_nxt, rdata_r, rdata_nxt;
  logic [7:0] op_r, op_nxt, oe_n_r, oe_n_nxt, interrupt_status_reg;
  logic [15:0] brg_cnt_r, brg_cnt_nxt, ct_cnt_r, ct_cnt_nxt;
  logic ct_out_r, ct_out_nxt, brg_tick, ct_tick;
  logic [1:0] hit, tx_empty, tx_ready, rx_ready, rx_full, rx_int, dbrk, rts_ctl, rts_neg;
  logic [1:0] tx16x, tx1x, rx1x;
  logic [7:0] ch_rdata [2];

  // Two identical channels
  for (genvar k = 0; k < 2; k++) begin : g_ch
    assign hit[k] = (addr_i[3] == 1'(k)) & (addr_i[2:0] < A_LOC_MAX);
    asc_channel u_ch (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .wr_i(wr_i & hit[k]), .rd_i(rd_i & hit[k]), .addr_i(addr_i[2:0]), .wdata_i(wdata_i),
      .rdata_o(ch_rdata[k]), .brg_tick_i(brg_tick), .ct_tick_i(ct_tick),
      .ext_tx_clk_i(ext_tx_clk_i[k]), .ext_rx_clk_i(ext_rx_clk_i[k]),
      .serial_in_i(serial_in_i[k]), .serial_out_o(serial_out_o[k]),
      .tx_empty_o(tx_empty[k]), .tx_ready_o(tx_ready[k]), .rx_ready_o(rx_ready[k]),
      .rx_full_o(rx_full[k]), .rx_int_o(rx_int[k]), .dbrk_o(dbrk[k]), .rts_ctl_o(rts_ctl[k]),
      .rts_neg_o(rts_neg[k]), .tx16x_o(tx16x[k]), .tx1x_o(tx1x[k]), .rx1x_o(rx1x[k])
    );
    assign interrupt_status_reg[ISR_CH_W*k+ISR_TX] = tx_empty[k];
    assign interrupt_status_reg[ISR_CH_W*k+ISR_RX] = rx_int[k];
    assign interrupt_status_reg[ISR_CH_W*k+ISR_DBRK] = dbrk[k];
    assign interrupt_status_reg[ISR_CH_W*k+3] = 1'b0;
  end

  // Rate generator and counter/timer dividers
  assign brg_tick = (brg_cnt_r == 16'h0000);
  assign ct_tick = (ct_cnt_r == 16'h0000);
  always_comb begin
    brg_cnt_nxt = brg_tick ? 16'(BRG_DIV - 1) : brg_cnt_r - 16'h0001;
    ct_cnt_nxt = ct_tick ? 16'(CT_DIV - 1) : ct_cnt_r - 16'h0001;
    ct_out_nxt = ct_out_r ^ ct_tick;
  end

  // Host registers, read data and pin functions
  always_comb begin
    opr_nxt = opr_r;
    output_pin_function_select_nxt = output_pin_function_select_r;
    imr_nxt = imr_r;
    rdata_nxt = rdata_r;
    if (wr_i && addr_i == A_OPSET) opr_nxt = opr_r | wdata_i;
    if (wr_i && addr_i == A_OPCLR) opr_nxt = opr_r & ~wdata_i;
    if (wr_i && addr_i == A_OUTPUT_PIN_FUNCTION_SELECT) output_pin_function_select_nxt = wdata_i;
    if (wr_i && addr_i == A_IMR) imr_nxt = wdata_i;
    if (rd_i) rdata_nxt = (|hit) ? ch_rdata[addr_i[3]] : (addr_i == A_IMR) ? interrupt_status_reg : 8'h00;
    op_nxt = ~opr_r;
    oe_n_nxt = 8'h00;
    for (int k = 0; k < 2; k++) begin
      if (rts_ctl[k]) op_nxt[k] = ~opr_r[k] | rts_neg[k];
      if (output_pin_function_select_r[4+k]) begin
        op_nxt[4+k] = 1'b0;
        oe_n_nxt[4+k] = ~rx_int[k];
      end
      if (output_pin_function_select_r[6+k]) begin
        op_nxt[6+k] = 1'b0;
        oe_n_nxt[6+k] = ~tx_ready[k];
      end
    end
    unique case (output_pin_function_select_r[3:2])
      OPS_LATCH: op_nxt[3] = ~opr_r[3];
      OPS_ALT1: op_nxt[3] = ct_out_r;
      OPS_ALT2: op_nxt[3] = tx1x[1];
      default: op_nxt[3] = rx1x[1];
    endcase
    unique case (output_pin_function_select_r[1:0])
      OPS_LATCH: op_nxt[2] = ~opr_r[2];
      OPS_ALT1: op_nxt[2] = tx16x[0];
      OPS_ALT2: op_nxt[2] = tx1x[0];
      default: op_nxt[2] = rx1x[0];
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      opr_r <= RST_BYTE;
      output_pin_function_select_r <= RST_BYTE;
      imr_r <= RST_BYTE;
      rdata_r <= RST_BYTE;
      op_r <= 8'hFF;
      oe_n_r <= 8'h00;
      brg_cnt_r <= 16'h0000;
      ct_cnt_r <= 16'h0000;
      ct_out_r <= 1'b0;
    end else begin
      opr_r <= opr_nxt;
      output_pin_function_select_r <= output_pin_function_select_nxt;
      imr_r <= imr_nxt;
      rdata_r <= rdata_nxt;
      op_r <= op_nxt;
      oe_n_r <= oe_n_nxt;
      brg_cnt_r <= brg_cnt_nxt;
      ct_cnt_r <= ct_cnt_nxt;
      ct_out_r <= ct_out_nxt;
    end
  end

  // Outputs
  assign rdata_o = rdata_r;
  assign op_o = op_r;
  assign op_oe_n_o = oe_n_r;
  assign irq_o = |(interrupt_status_reg & imr_r);
endmodule

/* tb/asc_top_asserts.sv */
// Port-level checks of the serial block top
`timescale 1ns/10ps
module asc_top_asserts import asc_pkg::*; #(
  parameter int unsigned BRG_DIV = 65,
  parameter int unsigned CT_DIV = 1000
) (
  // Clock, reset, host port
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  // Serial out and pins
  input wire logic [1:0] serial_out_o,
  input wire logic [7:0] op_o,
  input wire logic [7:0] op_oe_n_o,
  input wire logic irq_o
);
  localparam int unsigned BITC = 16 * BRG_DIV;
  logic [7:0] lat_r, lat_nxt, output_pin_function_select_r, output_pin_function_select_nxt, imr_r, imr_nxt;
  logic [1:0] rts_r, rts_nxt, txen_r, txen_nxt;
  logic [15:0] low_r, low_nxt;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // Mirror of host writes and low run length
  always_comb begin
    lat_nxt = lat_r;
    output_pin_function_select_nxt = output_pin_function_select_r;
    imr_nxt = imr_r;
    rts_nxt = rts_r;
    txen_nxt = txen_r;
    low_nxt = serial_out_o[0] ? 16'h0000 : low_r + 16'h0001;
    if (wr_i) begin
      case (addr_i)
        A_OPSET: lat_nxt = lat_r | wdata_i;
        A_OPCLR: lat_nxt = lat_r & ~wdata_i;
        A_OUTPUT_PIN_FUNCTION_SELECT: output_pin_function_select_nxt = wdata_i;
        A_IMR: imr_nxt = wdata_i;
        A_MR1: rts_nxt[0] = wdata_i[MR1_RXRTS];
        A_MR2: rts_nxt[1] = wdata_i[MR2_TXRTS];
        A_CR: txen_nxt[0] = txen_r[0] | wdata_i[CR_TXEN];
        A_CR | 4'h8: txen_nxt[1] = txen_r[1] | wdata_i[CR_TXEN];
        default: ;
      endcase
    end
  end
  // Register the mirror
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lat_r <= 8'h00;
      output_pin_function_select_r <= 8'h00;
      imr_r <= 8'h00;
      rts_r <= 2'h0;
      txen_r <= 2'h0;
      low_r <= 16'h0000;
    end else begin
      lat_r <= lat_nxt;
      output_pin_function_select_r <= output_pin_function_select_nxt;
      imr_r <= imr_nxt;
      rts_r <= rts_nxt;
      txen_r <= txen_nxt;
      low_r <= low_nxt;
    end
  end
  a_latch_pins: assert property (((op_o[7:4] ^ ~$past(lat_r[7:4])) & ~$past(output_pin_function_select_r[7:4])) == 4'h0)
    else $error("pin 7..4 not latch");
  a_clk_pins: assert property (($past(output_pin_function_select_r[3:0]) == 4'h0) |-> (op_o[3:2] == ~$past(lat_r[3:2])))
    else $error("pin 3..2 not latch");
  a_oe_latch: assert property ((op_oe_n_o & ~{$past(output_pin_function_select_r[7:4]), 4'h0}) == 8'h00)
    else $error("enable off on latch pin");
  a_od_low: assert property (($past(output_pin_function_select_r[7:4]) & ~op_oe_n_o[7:4] & op_o[7:4]) == 4'h0)
    else $error("open drain pin driven high");
  a_rts_plain: assert property (($past(rts_r) == 2'h0) |-> (op_o[0] == !$past(lat_r[0])))
    else $error("pin 0 not plain");
  a_rts_negate: assert property (!op_o[0] |-> $past(lat_r[0]))
    else $error("pin 0 low without latch");
  a_bit_whole: assert property ($rose(serial_out_o[0]) |-> (low_r != 16'h0000 && low_r % BITC == 0))
    else $error("low run not whole bits");
  a_idle_mark: assert property ((serial_out_o | txen_r) == 2'b11)
    else $error("line not mark while unused");
  a_irq_masked: assert property ((imr_r == 8'h00) |-> !irq_o)
    else $error("irq with mask clear");
  a_rdata_hold: assert property (!$past(rd_i) |-> $stable(rdata_o))
    else $error("read data moved");
  // Main scenarios
  c_tx: cover property ($rose(serial_out_o[0]));
  c_irq: cover property ($rose(irq_o));
  c_od: cover property (!op_oe_n_o[6]);
endmodule
bind asc_top asc_top_asserts #(.BRG_DIV(BRG_DIV), .CT_DIV(CT_DIV)) u_chk (
  .clk_sys_i, .nrst_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
  .serial_out_o, .op_o, .op_oe_n_o, .irq_o);

/* tb/asc_far_end.sv */
// Far-end serial transmitter and receiver
`timescale 1ns/10ps
module asc_far_end #(
  parameter int BITC = 32
) (
  // Clock
  input wire logic clk_sys_i,
  // Serial lines and receive frame length
  input wire logic line_i,
  output logic line_o,
  input wire logic [3:0] len_i
);
  logic [11:0] got_q[$];
  logic [11:0] sh;
  initial line_o = 1'b1;
  // Drive a frame, bit 0 first
  task automatic send(input logic [11:0] fr, input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge clk_sys_i);
      #1 line_o = fr[i];
      repeat (BITC - 1) @(posedge clk_sys_i);
    end
  endtask
  // Short space pulse
  task automatic glitch(input int n);
    @(posedge clk_sys_i);
    #1 line_o = 1'b0;
    repeat (n) @(posedge clk_sys_i);
    #1 line_o = 1'b1;
  endtask
  // Sample mid-bit, low bit first
  always begin
    @(negedge line_i);
    repeat (BITC / 2) @(posedge clk_sys_i);
    if (!line_i) begin
      sh = 12'h000;
      for (int i = 0; i < len_i; i++) begin
        repeat (BITC) @(posedge clk_sys_i);
        sh[i] = line_i;
      end
      got_q.push_back(sh);
    end
  end
endmodule

/* tb/tb_top.sv */
// Self-checking bench of the serial block
`timescale 1ns/10ps
module tb_top;
  import asc_pkg::*;
  localparam int BITC = 32;
  logic clk_sys_i, nrst_i, wr_i, rd_i, irq_o, far_line;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, op_o, op_oe_n_o, v, lat, sr;
  logic [7:0] d[5];
  logic [1:0] serial_in_i, serial_out_o, ext_clk;
  int n_mismatch, num_checks, seed;
  asc_top #(.BRG_DIV(2), .CT_DIV(4)) u_dut (
    .clk_sys_i, .nrst_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .serial_in_i, .serial_out_o,
    .ext_tx_clk_i(ext_clk), .ext_rx_clk_i(ext_clk), .op_o, .op_oe_n_o, .irq_o);
  assign serial_in_i = {1'b1, far_line};
  asc_far_end #(.BITC(BITC)) u_far (.clk_sys_i, .line_i(serial_out_o[0]), .line_o(far_line), .len_i(4'h9));
  // Compare and host cycles
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s %h/%h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk_sys_i);
    #1 wr_i = 1'b1;
    addr_i = a;
    wdata_i = x;
    @(posedge clk_sys_i);
    #1 wr_i = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge clk_sys_i);
    #1 rd_i = 1'b1;
    addr_i = a;
    @(posedge clk_sys_i);
    #1 rd_i = 1'b0;
    x = rdata_o;
  endtask
  task automatic wait_sr(input logic [7:0] m, input logic [7:0] x);
    for (int n = 0; n < 2000; n++) begin
      rd(A_SR, sr);
      if ((sr & m) === x) return;
    end
    chk(sr & m, x, "status wait");
  endtask
  // Start, data low first, parity 1 bad 2 good, stop
  function automatic logic [11:0] frame(input logic [7:0] x, input int par, input logic stp);
    if (par == 0) return {2'b11, stp, x, 1'b0};
    return {1'b1, stp, (par == 2) ? ^x : ~^x, x, 1'b0};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Clock and watchdog
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // External 16x clock, one rising edge per two cycles like the rate generator
  initial begin
    ext_clk = 2'b00;
    forever @(posedge clk_sys_i) #1 ext_clk = ~ext_clk;
  end
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    n_mismatch++;
    summarize();
  end
  // Main sequence
  initial begin
    seed = 31723;
    n_mismatch = 0;
    num_checks = 0;
    {wr_i, rd_i, nrst_i} = 3'b000;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    lat = 8'h00;
    repeat (10) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    chk({op_o[7:2], serial_out_o}, 8'hFF, "reset");
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      wr(i[0] ? A_OPCLR : A_OPSET, v);
      lat = i[0] ? lat & ~v : lat | v;
      @(posedge clk_sys_i);
      #1 chk(op_o, ~lat, "latch");
    end
    // Pin 3 carries the counter/timer square wave
    wr(A_OUTPUT_PIN_FUNCTION_SELECT, 8'h04);
    repeat (4) @(posedge clk_sys_i);
    #1 v[0] = op_o[3];
    repeat (4) @(posedge clk_sys_i);
    #1 chk({7'h00, op_o[3] ^ v[0]}, 8'h01, "timer pin");
    // Two chars, disable while one waits, third refused
    wr(A_MR1, 8'h13);
    wr(A_CR, 8'h05);
    wr(A_OUTPUT_PIN_FUNCTION_SELECT, 8'h40);
    wr(A_IMR, 8'h01);
    #1 chk({op_oe_n_o[6], op_o[6], 5'h00, irq_o}, 8'h01, "ready pin");
    for (int i = 0; i < 3; i++) d[i] = 8'($random(seed));
    wr(A_DATA, d[0]);
    wait_sr(8'h04, 8'h04);
    wr(A_DATA, d[1]);
    wr(A_CR, 8'h08);
    wr(A_DATA, d[2]);
    chk({7'h00, irq_o}, 8'h00, "busy");
    wait_sr(8'h08, 8'h08);
    repeat (BITC) @(posedge clk_sys_i);
    chk({irq_o, 7'(u_far.got_q.size())}, 8'h82, "drain");
    chk(u_far.got_q[0][7:0], d[0], "char 0");
    chk(u_far.got_q[1][7:0], d[1], "char 1");
    // Five chars into the queue, overrun
    wr(A_IMR, 8'h02);
    wr(A_MR1, 8'h93);
    wr(A_OPSET, 8'h01);
    wr(A_OUTPUT_PIN_FUNCTION_SELECT, 8'h50);
    repeat (2) @(posedge clk_sys_i);
    #1 chk({7'h00, op_o[0]}, 8'h00, "rts on");
    for (int i = 0; i < 5; i++) begin
      d[i] = 8'($random(seed));
      u_far.send(frame(d[i], 0, 1'b1), 10);
    end
    rd(A_SR, sr);
    chk(sr & 8'h13, 8'h13, "full");
    chk({op_o[0], op_oe_n_o[4], 5'h00, irq_o}, 8'h81, "rts off");
    for (int i = 0; i < 3; i++) begin
      rd(A_DATA, v);
      chk(v, d[i], "order");
    end
    wr(A_MR1, 8'h53);
    #1 chk({7'h00, irq_o}, 8'h00, "full sel");
    wr(A_MR1, 8'h13);
    #1 chk({7'h00, irq_o}, 8'h01, "ready sel");
    rd(A_DATA, v);
    chk(v, d[4], "overwrite");
    u_far.glitch(8);
    repeat (BITC * 2) @(posedge clk_sys_i);
    rd(A_SR, sr);
    chk(sr & 8'h01, 8'h00, "noise");
    // Framing error, bad parity, good parity
    for (int k = 0; k < 3; k++) begin
      v = 8'($random(seed)) | 8'h01;
      wr(A_MR1, k == 0 ? 8'h13 : 8'h03);
      wr(A_CSR, k == 2 ? 8'h0A : 8'h00);
      u_far.send(frame(v, k, k != 0), 11);
      wait_sr(8'h01, 8'h01);
      chk(sr & 8'h60, k == 0 ? 8'h40 : k == 1 ? 8'h20 : 8'h00, "flags");
      rd(A_DATA, sr);
      chk(sr, v, "err char");
    end
    // Long space, then mark
    wr(A_IMR, 8'h04);
    u_far.send(12'h000, 12);
    u_far.send(12'h000, 12);
    chk({7'h00, irq_o}, 8'h01, "brk begin");
    wr(A_CR, 8'h20);
    rd(A_IMR, v);
    chk(v & 8'h04, 8'h00, "dbrk clr");
    u_far.send(12'hFFF, 2);
    rd(A_IMR, v);
    chk(v & 8'h04, 8'h04, "brk end");
    rd(A_SR, sr);
    chk(sr & 8'h81, 8'h81, "brk flag");
    rd(A_DATA, v);
    chk(v, 8'h00, "brk char");
    rd(A_SR, sr);
    chk(sr & 8'h01, 8'h00, "one brk");
    summarize();
  end
endmodule
